// ---- core/ddr_mode_params.svh ----
// Offsets, field positions, reset values and timing counts
`ifndef DDR_MODE_PARAMS_SVH
`define DDR_MODE_PARAMS_SVH
`define DMC_OFFSET     8'h70
`define DMC_RESET      32'h0000_0081
`define DMC_REV_HI     31
`define DMC_REV_LO     30
`define DMC_INIT_BIT   29
`define DMC_CHANNEL_COUNT_HI    23
`define DMC_CHANNEL_COUNT_LO    22
`define DMC_DATA_INTEGRITY_MODE_HI    21
`define DMC_DATA_INTEGRITY_MODE_LO    20
`define DMC_LOCK_BIT   15
`define DMC_RMS_HI     9
`define DMC_RMS_LO     7
`define DMC_SMS_HI     6
`define DMC_SMS_LO     4
`define DMC_LOW_HI     3
`define DMC_REV_VAL    2'h0
`define DMC_CHANNEL_COUNT_VAL   2'h0
`define DMC_DATA_INTEGRITY_MODE_NOECC 2'h0
`define DMC_LOW_VAL    4'h1
`define RMS_OFF        3'h0
`define RMS_156        3'h1
`define RMS_78         3'h2
`define RMS_FAST       3'h7
`define SMS_POST_RST   3'h0
`define SMS_NOP        3'h1
`define CLK_PERIOD_NS  40
`define REF_156_NS     15600
`define REF_78_NS      7800
`define REF_156_CYC    (`REF_156_NS / `CLK_PERIOD_NS)
`define REF_78_CYC     (`REF_78_NS / `CLK_PERIOD_NS)
`define REF_FAST_CYC   64
`define TRAS_CYC       6
`define TRP_CYC        3
`endif

// ---- core/ddr_mode_pkg.sv ----
// Types shared by the mode and refresh control block
package ddr_mode_pkg;
   typedef enum logic [1:0] {
      REQ_ACT = 2'h0,
      REQ_RD  = 2'h1,
      REQ_WR  = 2'h2
   } req_kind_e;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD  = 3'h2,
      CMD_WR  = 3'h3,
      CMD_REF = 3'h4
   } cmd_e;
   typedef enum logic [1:0] {
      PW_HOLD = 2'b01,
      PW_RUN  = 2'b10
   } power_st_e;
endpackage

// ---- core/refresh_timer_if.sv ----
// Link between the mode register and the refresh interval timer
`timescale 1ns/1ps
interface refresh_timer_if;
   logic [2:0] rate;
   logic       enable;
   logic       restart;
   logic       tick;
   modport timer (input rate, input enable, input restart, output tick);
   modport ctrl  (output rate, output enable, output restart, input tick);
endinterface

// ---- core/refresh_timer.sv ----
// Refresh interval counter with rate decode and restart
`timescale 1ns/1ps
`include "ddr_mode_params.svh"
module refresh_timer #(
   parameter int CNT_W = 9
) (
   input wire logic     i_clk,
   input wire logic     i_rst,
   refresh_timer_if.timer tif
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] interval;
   logic             at_end;
   logic             tick;

   if ((2 ** CNT_W) <= `REF_156_CYC) begin : g_chk
      $error("CNT_W too small for the slowest refresh interval");
   end

   always_comb begin
      unique case (tif.rate)
         `RMS_156:  interval = CNT_W'(`REF_156_CYC);
         `RMS_78:   interval = CNT_W'(`REF_78_CYC);
         `RMS_FAST: interval = CNT_W'(`REF_FAST_CYC);
         default:   interval = '1;
      endcase
   end

   assign at_end     = count == interval - CNT_W'(1);
   assign next_count = (tif.restart || !tif.enable || at_end) ? '0
                       : count + CNT_W'(1);
   assign tif.tick   = tick;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= tif.enable && !tif.restart && at_end;
      end
   end

   property p_restart_clears;
      @(posedge i_clk) disable iff (i_rst)
      tif.restart |=> count == '0;
   endproperty
   a_restart_clears: assert property (p_restart_clears)
      else $error("refresh counter not cleared on rate change");

   property p_fast_spacing;
      @(posedge i_clk) disable iff (i_rst)
      (tick && tif.enable && tif.rate == `RMS_FAST && !tif.restart)
      |=> !tick [*8];
   endproperty
   a_fast_spacing: assert property (p_fast_spacing)
      else $error("fast refresh ticks too close together");
endmodule

// ---- core/ddr_mode_refresh_control.sv ----
// Mode register, refresh control and command gating for one DDR channel
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "ddr_mode_params.svh"
module ddr_mode_refresh_control
   import ddr_mode_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int BANKS  = 4,
   parameter int CKE_N  = 2
) (
   input  wire logic                    I_CORE_CLK,
   input  wire logic                    I_RST,
   input  wire logic                    I_PSEL,
   input  wire logic                    I_PENABLE,
   input  wire logic                    I_PWRITE,
   input  wire logic [ADDR_W-1:0]       I_PADDR,
   input  wire logic [31:0]             I_PWDATA,
   input  wire logic [3:0]              I_PSTRB,
   output      logic [31:0]             O_PRDATA,
   output      logic                    O_PREADY,
   output      logic                    O_PSLVERR,
   input  wire logic                    I_REQ_VALID,
   input  wire ddr_mode_pkg::req_kind_e I_REQ_KIND,
   input  wire logic [$clog2(BANKS)-1:0] I_REQ_BANK,
   input  wire logic                    I_REQ_AP,
   output      logic                    O_REQ_READY,
   output      ddr_mode_pkg::cmd_e      O_CMD,
   output      logic [$clog2(BANKS)-1:0] O_CMD_BANK,
   output      logic                    O_CMD_AP,
   output      logic [CKE_N-1:0]        O_CKE,
   output      logic                    O_REFRESH_ON,
   output      logic                    O_ECC_OE,
   output      logic                    O_ECC_SENSE_EN,
   output      logic                    O_RMW_EN
);
   import ddr_mode_pkg::*;

   localparam int BW = $clog2(BANKS);
   localparam int TW = 4;

   if (ADDR_W < 7 || BANKS < 2 || CKE_N < 1) begin : g_chk
      $error("unsupported parameter values");
   end
   if (`TRAS_CYC >= 2 ** TW || `TRP_CYC >= 2 ** TW) begin : g_chk_t
      $error("timing counts exceed counter width");
   end

   // Mode register fields
   logic        init_done;
   logic        lockout;
   logic [2:0]  refresh_rate_select;
   logic [2:0]  special_mode_select;
   power_st_e   pw_st;
   power_st_e   next_pw_st;

   // Bus decode
   wire         setup   = I_PSEL && !I_PENABLE;
   wire         hit     = I_PADDR == ADDR_W'(`DMC_OFFSET);
   wire         fire    = I_PSEL && I_PENABLE && O_PREADY;
   wire         wr_fire = fire && I_PWRITE && hit;
   wire [31:0]  wmask   = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}},
                           {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
   logic [31:0] rd_val;
   wire  [31:0] merged  = (I_PWDATA & wmask) | (rd_val & ~wmask);
   wire  [2:0]  new_rms = merged[`DMC_RMS_HI:`DMC_RMS_LO];
   wire  [2:0]  new_sms = merged[`DMC_SMS_HI:`DMC_SMS_LO];

   // Read-only fields are constants; the no-ECC mode cannot be changed
   always_comb begin
      rd_val = '0;
      rd_val[`DMC_REV_HI:`DMC_REV_LO]   = `DMC_REV_VAL;
      rd_val[`DMC_INIT_BIT]             = init_done;
      rd_val[`DMC_CHANNEL_COUNT_HI:`DMC_CHANNEL_COUNT_LO] = `DMC_CHANNEL_COUNT_VAL;
      rd_val[`DMC_DATA_INTEGRITY_MODE_HI:`DMC_DATA_INTEGRITY_MODE_LO] = `DMC_DATA_INTEGRITY_MODE_NOECC;
      rd_val[`DMC_LOCK_BIT]             = lockout;
      rd_val[`DMC_RMS_HI:`DMC_RMS_LO]   = refresh_rate_select;
      rd_val[`DMC_SMS_HI:`DMC_SMS_LO]   = special_mode_select;
      rd_val[`DMC_LOW_HI:0]             = `DMC_LOW_VAL;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= '0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= setup;
         O_PRDATA  <= (setup && !I_PWRITE && hit) ? rd_val : '0;
         O_PSLVERR <= setup && !hit;
      end
   end

   // Register fields; reset image equals the documented default
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         init_done <= 1'(`DMC_RESET >> `DMC_INIT_BIT);
         lockout   <= 1'(`DMC_RESET >> `DMC_LOCK_BIT);
         refresh_rate_select       <= 3'(`DMC_RESET >> `DMC_RMS_LO);
         special_mode_select       <= `SMS_POST_RST;
      end else if (wr_fire) begin
         init_done <= merged[`DMC_INIT_BIT];
         lockout   <= merged[`DMC_LOCK_BIT];
         refresh_rate_select       <= new_rms;
         special_mode_select       <= new_sms;
      end
   end

   // Clock enables: only a nonzero special mode write releases them
   always_comb begin
      unique case (pw_st)
         PW_HOLD: next_pw_st = (wr_fire && new_sms != `SMS_POST_RST)
                               ? PW_RUN : PW_HOLD;
         PW_RUN:  next_pw_st = PW_RUN;
         default: next_pw_st = PW_HOLD;
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pw_st <= PW_HOLD;
         O_CKE <= '0;
      end else begin
         pw_st <= next_pw_st;
         O_CKE <= {CKE_N{next_pw_st == PW_RUN}};
      end
   end

   // Refresh timer
   refresh_timer_if tif ();
   wire rate_legal = refresh_rate_select == `RMS_156 || refresh_rate_select == `RMS_78
                     || refresh_rate_select == `RMS_FAST;
   assign tif.rate    = refresh_rate_select;
   assign tif.enable  = init_done && rate_legal;
   assign tif.restart = wr_fire && new_rms != refresh_rate_select;

   refresh_timer #(
      .CNT_W (9)
   ) u_timer (
      .i_clk (I_CORE_CLK),
      .i_rst (I_RST),
      .tif   (tif.timer)
   );

   // Request gating and per-bank timing
   logic [TW-1:0] tras_cnt [BANKS];
   logic [TW-1:0] trp_cnt  [BANKS];
   logic [BANKS-1:0] tras_ok;
   logic [BANKS-1:0] trp_ok;
   logic          ref_pend;

   wire nop_mode  = special_mode_select == `SMS_NOP;
   wire running   = pw_st == PW_RUN;
   wire accept    = I_REQ_VALID && O_REQ_READY;
   wire is_act    = I_REQ_KIND == REQ_ACT;
   wire ap_issue  = accept && !is_act && I_REQ_AP && !nop_mode;
   wire act_issue = accept && is_act && !nop_mode;
   wire bank_ok   = nop_mode || (is_act ? trp_ok[I_REQ_BANK]
                    : (!I_REQ_AP || lockout || tras_ok[I_REQ_BANK]));
   wire ref_issue = ref_pend && running && !accept && tif.enable;

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      wire hit_b = I_REQ_BANK == BW'(b);
      assign tras_ok[b] = tras_cnt[b] == '0;
      assign trp_ok[b]  = trp_cnt[b] == '0;
      always_ff @(posedge I_CORE_CLK) begin
         if (I_RST) begin
            tras_cnt[b] <= '0;
            trp_cnt[b]  <= '0;
         end else begin
            tras_cnt[b] <= (act_issue && hit_b) ? TW'(`TRAS_CYC)
                           : tras_cnt[b] - TW'(!tras_ok[b]);
            trp_cnt[b]  <= (ap_issue && hit_b) ? TW'(`TRP_CYC)
                           : trp_cnt[b] - TW'(!trp_ok[b]);
         end
      end
   end

   // Ready is decided a cycle ahead from held request fields
   wire next_ready = running && I_REQ_VALID && !accept
                     && !ref_pend && bank_ok;

   cmd_e next_cmd;
   always_comb begin
      next_cmd = CMD_NOP;
      if (ref_issue) begin
         next_cmd = CMD_REF;
      end else if (accept && !nop_mode) begin
         unique case (I_REQ_KIND)
            REQ_ACT: next_cmd = CMD_ACT;
            REQ_RD:  next_cmd = CMD_RD;
            REQ_WR:  next_cmd = CMD_WR;
            default: next_cmd = CMD_NOP;
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         ref_pend    <= 1'b0;
         O_REQ_READY <= 1'b0;
         O_CMD       <= CMD_NOP;
         O_CMD_BANK  <= '0;
         O_CMD_AP    <= 1'b0;
      end else begin
         // A tick in the issue cycle keeps the request pending; a
         // pending refresh is dropped once refresh is switched off
         ref_pend    <= tif.tick || (ref_pend && !ref_issue && tif.enable);
         O_REQ_READY <= next_ready;
         O_CMD       <= next_cmd;
         O_CMD_BANK  <= accept ? I_REQ_BANK : '0;
         O_CMD_AP    <= ap_issue;
      end
   end

   // No-ECC: the ECC lanes are never driven or sensed
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_REFRESH_ON   <= 1'b0;
         O_ECC_OE       <= 1'b0;
         O_ECC_SENSE_EN <= 1'b0;
         O_RMW_EN       <= 1'b0;
      end else begin
         O_REFRESH_ON   <= tif.enable;
         O_ECC_OE       <= 1'b0;
         O_ECC_SENSE_EN <= 1'b0;
         O_RMW_EN       <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   property p_ref_needs_init;
      (O_CMD == CMD_REF) |-> $past(init_done);
   endproperty
   a_ref_needs_init: assert property (p_ref_needs_init)
      else $error("refresh issued without init done");

   property p_reserved_rate_off;
      (!rate_legal || !init_done) |=> !O_REFRESH_ON;
   endproperty
   a_reserved_rate_off: assert property (p_reserved_rate_off)
      else $error("refresh on with reserved rate or no init");

   property p_ap_tras;
      (ap_issue && !lockout) |-> tras_ok[I_REQ_BANK];
   endproperty
   a_ap_tras: assert property (p_ap_tras)
      else $error("auto precharge before row active time");

   property p_act_trp;
      act_issue |-> trp_ok[I_REQ_BANK];
   endproperty
   a_act_trp: assert property (p_act_trp)
      else $error("activate inside row precharge time");

   property p_ap_with_rw;
      O_CMD_AP |-> (O_CMD == CMD_RD || O_CMD == CMD_WR);
   endproperty
   a_ap_with_rw: assert property (p_ap_with_rw)
      else $error("auto precharge without read or write");

   property p_reset_state;
      $past(I_RST) |-> (special_mode_select == `SMS_POST_RST && O_CKE == '0
                        && rd_val == `DMC_RESET);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("wrong state after reset");

   property p_cke_cause;
      $rose(O_CKE[0]) |-> $past(wr_fire && new_sms != `SMS_POST_RST);
   endproperty
   a_cke_cause: assert property (p_cke_cause)
      else $error("clock enable rose without a mode write");

   property p_cke_rise;
      (wr_fire && new_sms != `SMS_POST_RST) |=> O_CKE == '1;
   endproperty
   a_cke_rise: assert property (p_cke_rise)
      else $error("clock enables not raised");

   property p_zero_write_quiet;
      (wr_fire && new_sms == `SMS_POST_RST && pw_st == PW_HOLD)
      |=> O_CKE == '0 ##1 O_CKE == '0;
   endproperty
   a_zero_write_quiet: assert property (p_zero_write_quiet)
      else $error("writing mode 000 had a side effect");

   property p_nop_mode;
      (accept && nop_mode) |=> O_CMD == CMD_NOP && !O_CMD_AP;
   endproperty
   a_nop_mode: assert property (p_nop_mode)
      else $error("access not turned into a no-operation");

   property p_no_ecc;
      !O_ECC_OE && !O_ECC_SENSE_EN && !O_RMW_EN;
   endproperty
   a_no_ecc: assert property (p_no_ecc)
      else $error("ECC lanes active in no-ECC mode");
endmodule

// ---- verification/ddr_mem_model.sv ----
// Behavioural DDR memory that logs refresh commands and counts illegal ones
`timescale 1ns/1ps
`include "ddr_mode_params.svh"
module ddr_mem_model
   import ddr_mode_pkg::*;
(
   input wire logic               i_clk,
   input wire ddr_mode_pkg::cmd_e i_cmd,
   input wire logic [1:0]         i_bank,
   input wire logic               i_ap,
   input wire logic [1:0]         i_cke
);
   int cyc;
   int ref_cnt;
   int last_ref;
   int bad;
   int ap_at [4];
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (i_cmd == CMD_REF) begin
         ref_cnt <= ref_cnt + 1;
         last_ref <= cyc;
      end
      // Real parts ignore commands while their clocks are disabled
      if (i_cke != 2'b11 && i_cmd != CMD_NOP) begin
         bad <= bad + 1;
      end
      if (i_cmd == CMD_ACT && cyc - ap_at[i_bank] < `TRP_CYC) begin
         bad <= bad + 1;
      end
      if (i_ap && i_cmd != CMD_RD && i_cmd != CMD_WR) begin
         bad <= bad + 1;
      end
      if (i_ap && (i_cmd == CMD_RD || i_cmd == CMD_WR)) begin
         ap_at[i_bank] <= cyc;
      end
   end
endmodule

// ---- verification/test_ddr_mode_refresh_control.sv ----
// Self-checking bench for the mode and refresh control block
`timescale 1ns/1ps
`include "ddr_mode_params.svh"
module test_ddr_mode_refresh_control;
   import ddr_mode_pkg::*;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        valid;
   req_kind_e   kind;
   logic [1:0]  bank;
   logic        rap;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ready;
   cmd_e        cmd;
   logic [1:0]  cmd_bank;
   logic        cmd_ap;
   logic [1:0]  cke;
   logic        ref_on;
   logic        ecc_oe;
   logic        sense_en;
   logic        rmw_en;
   logic [31:0] q;
   logic        err;
   int          t1;
   int          t2;
   int          t3;
   int          n_mismatch;
   int          n_tests;

   ddr_mode_refresh_control i_dut (
      .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_REQ_VALID(valid), .I_REQ_KIND(kind),
      .I_REQ_BANK(bank), .I_REQ_AP(rap), .O_REQ_READY(ready),
      .O_CMD(cmd), .O_CMD_BANK(cmd_bank), .O_CMD_AP(cmd_ap),
      .O_CKE(cke), .O_REFRESH_ON(ref_on), .O_ECC_OE(ecc_oe),
      .O_ECC_SENSE_EN(sense_en), .O_RMW_EN(rmw_en));
   ddr_mem_model u_mem (
      .i_clk(clk), .i_cmd(cmd), .i_bank(cmd_bank), .i_ap(cmd_ap),
      .i_cke(cke));

   always #20 clk = ~clk;

   function automatic logic [31:0] mk(input logic i, input logic l,
                                      input logic [2:0] r,
                                      input logic [2:0] s);
      return {2'h0, i, 13'h0, l, 5'h0, r, s, 4'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Request is held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic req(input req_kind_e k, input logic [1:0] b,
                      input logic ap, output int t);
      @(posedge clk);
      valid <= 1'b1;
      kind <= k;
      bank <= b;
      rap <= ap;
      @(posedge clk);
      while (ready !== 1'b1) begin
         @(posedge clk);
      end
      t = u_mem.cyc;
      valid <= 1'b0;
      @(negedge clk);
   endtask

   task automatic wait_ref(input int lim, output int t);
      int n0;
      n0 = u_mem.ref_cnt;
      for (int i = 0; i < lim && u_mem.ref_cnt == n0; i++) begin
         @(negedge clk);
      end
      chk("ref_seen", 1, u_mem.ref_cnt != n0);
      t = u_mem.last_ref;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out;
   end

   initial begin
      clk = 0;
      rst = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      pstrb = 4'hf;
      valid = 0;
      kind = REQ_ACT;
      bank = 0;
      rap = 0;
      repeat (3) @(negedge clk);
      chk("cke_in_reset", 0, cke);
      @(posedge clk);
      rst <= 1'b0;
      apb(0, `DMC_OFFSET, 0);
      chk("reset_value", `DMC_RESET, q);
      chk("mapped_err", 0, err);
      chk("cke_after_reset", 0, cke);
      chk("side_outs", 0, {ecc_oe, sense_en, rmw_en, ref_on});
      apb(1, 8'h74, 32'h2000_0080);
      chk("unmapped_err", 1, err);
      apb(0, `DMC_OFFSET, 0);
      chk("unmapped_write", `DMC_RESET, q);
      apb(1, `DMC_OFFSET, 32'he0f0_800e);
      apb(0, `DMC_OFFSET, 0);
      chk("ro_fields", 32'h2000_8001, q);
      apb(1, `DMC_OFFSET, mk(0, 0, 1, 0));
      repeat (2) @(negedge clk);
      chk("refresh_no_init", 0, ref_on);
      for (int r = 0; r < 8; r++) begin
         apb(1, `DMC_OFFSET, mk(1, 0, r[2:0], 0));
         repeat (2) @(negedge clk);
         chk("refresh_on", r == 1 || r == 2 || r == 7, ref_on);
      end
      apb(1, `DMC_OFFSET, mk(1, 0, 0, 0));
      repeat (2) @(negedge clk);
      chk("cke_sms_zero", 0, cke);
      apb(1, `DMC_OFFSET, mk(1, 0, 0, 1));
      repeat (2) @(negedge clk);
      chk("cke_on", 2'b11, cke);
      for (int k = 0; k < 3; k++) begin
         req(req_kind_e'(k), 2'(k), 1'b0, t1);
         chk("nop_mode", CMD_NOP, cmd);
      end
      apb(1, `DMC_OFFSET, mk(1, 0, 0, 2));
      req(REQ_ACT, 1, 0, t1);
      chk("act_cmd", {CMD_ACT, 2'h1}, {cmd, cmd_bank});
      req(REQ_RD, 1, 1, t2);
      chk("rd_ap", {CMD_RD, 3'h3}, {cmd, cmd_bank, cmd_ap});
      chk("tras_wait", 1, t2 - t1 >= `TRAS_CYC);
      req(REQ_ACT, 2, 0, t1);
      req(REQ_WR, 2, 0, t2);
      chk("wr_no_ap", {CMD_WR, 3'h4}, {cmd, cmd_bank, cmd_ap});
      chk("no_ap_fast", 1, t2 - t1 < `TRAS_CYC);
      apb(1, `DMC_OFFSET, mk(1, 1, 0, 2));
      req(REQ_ACT, 3, 0, t1);
      req(REQ_WR, 3, 1, t2);
      chk("wr_ap", {CMD_WR, 3'h7}, {cmd, cmd_bank, cmd_ap});
      chk("lockout_fast", 1, t2 - t1 < `TRAS_CYC);
      req(REQ_ACT, 3, 0, t3);
      chk("trp_wait", 1, t3 - t2 >= `TRP_CYC);
      apb(1, `DMC_OFFSET, mk(1, 0, 7, 2));
      wait_ref(100, t1);
      wait_ref(100, t2);
      chk("fast_gap", `REF_FAST_CYC, t2 - t1);
      repeat (40) @(posedge clk);
      apb(1, `DMC_OFFSET, mk(1, 0, 2, 2));
      @(negedge clk);
      t1 = u_mem.cyc;
      wait_ref(300, t2);
      chk("restart_78", 1, (t2 - t1) inside
          {[`REF_78_CYC - 5 : `REF_78_CYC + 10]});
      apb(1, `DMC_OFFSET, mk(1, 0, 1, 2));
      @(negedge clk);
      t1 = u_mem.cyc;
      wait_ref(500, t2);
      chk("rate_156", 1, (t2 - t1) inside
          {[`REF_156_CYC - 5 : `REF_156_CYC + 10]});
      @(posedge clk);
      pstrb <= 4'h2;
      apb(1, `DMC_OFFSET, mk(0, 1, 7, 5));
      pstrb <= 4'hf;
      apb(0, `DMC_OFFSET, 0);
      chk("byte_strobe", mk(1, 1, 7, 2) | 32'h1, q);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(negedge clk);
      chk("cke_reset2", 0, {ref_on, cke});
      @(posedge clk);
      rst <= 1'b0;
      apb(0, `DMC_OFFSET, 0);
      chk("reset2_value", `DMC_RESET, q);
      chk("cke_hold", 0, cke);
      chk("mem_faults", 0, u_mem.bad);
      close_out;
   end
endmodule
